// ### pkg/breaker_failure_pkg.sv
// constants and decode helpers for the breaker-failure supervision block
//Contract
//- release below 97 percent of pick-up level
//- one phase level, any phase picks up
//- residual source 0 off, a, b, computed
//- criterion selector codes 0 to 10, default current
//- phase level 0.01 to 40.00 In
//- residual level 0.005 to 40.000 In
//- start only while blocking input inactive
//- signal pick-up in same evaluation, no delay
//- status code normal, start, retrip, failure, blocked
//- blocking input sampled at each cycle start
//- blocked pick-up asserts blocked, no timers
//- blocking during start drops start, releases timers
//- blocking raises notification and captured event
//- one pick-up starts both timers together
//- retrip enable gates retrip output, default yes
//- retrip after delay, 0 to 1800 s
//- failure output after delay, 0 to 1800 s
//- current only: timers follow current alone
//- current and output: both needed to run
//- current or output: either keeps timers running
//- evaluation on 5 ms measurement tick
//- start, retrip, failure active, blocked outputs
package breaker_failure_pkg;

  localparam int MAG_W = 16;
  localparam int PH_LEVEL_W = 12;
  localparam int RES_LEVEL_W = 16;
  localparam int DELAY_W = 19;
  localparam int ADDR_W = 8;

  // time base and delay limits
  localparam int TICK_MS = 5;
  localparam int DELAY_MAX_S = 1800;
  localparam logic [DELAY_W-1:0] DELAY_MAX_TICKS = DELAY_W'(DELAY_MAX_S * 1000 / TICK_MS);
  localparam logic [DELAY_W-1:0] RETRIP_DELAY_RST = DELAY_W'(100 / TICK_MS);
  localparam logic [DELAY_W-1:0] FAIL_DELAY_RST = DELAY_W'(200 / TICK_MS);

  // levels: phase in 0.01 In, residual and magnitudes in 0.001 In
  localparam logic [PH_LEVEL_W-1:0] PH_LEVEL_MIN = 12'h0001;
  localparam logic [PH_LEVEL_W-1:0] PH_LEVEL_MAX = 12'h0FA0;
  localparam logic [PH_LEVEL_W-1:0] PH_LEVEL_RST = 12'h0014;
  localparam logic [RES_LEVEL_W-1:0] RES_LEVEL_MIN = 16'h0005;
  localparam logic [RES_LEVEL_W-1:0] RES_LEVEL_MAX = 16'h9C40;
  localparam logic [RES_LEVEL_W-1:0] RES_LEVEL_RST = 16'h04B0;
  localparam int PH_TO_MILLI = 10;
  localparam int RELEASE_PCT = 97;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_PH_LEVEL = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_RES_LEVEL = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_RETRIP_DELAY = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_FAIL_DELAY = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_BLOCK_EVT = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_EVT_PHASE = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_EVT_RES = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_ELAPSED = 8'h24;

  // control field positions and reset values
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_RESSEL_LSB = 4;
  localparam int CTRL_RETRIP_EN_BIT = 8;
  localparam int EVT_FLAG_BIT = 31;
  localparam logic [3:0] MODE_RST = 4'h0;
  localparam logic [1:0] RESSEL_RST = 2'h0;
  localparam logic RETRIP_EN_RST = 1'b1;

  // criterion selector codes
  localparam logic [3:0] MODE_CUR = 4'h0;
  localparam logic [3:0] MODE_DO = 4'h1;
  localparam logic [3:0] MODE_SIG = 4'h2;
  localparam logic [3:0] MODE_CUR_AND_DO = 4'h3;
  localparam logic [3:0] MODE_CUR_OR_DO = 4'h4;
  localparam logic [3:0] MODE_CUR_AND_SIG = 4'h5;
  localparam logic [3:0] MODE_CUR_OR_SIG = 4'h6;
  localparam logic [3:0] MODE_SIG_AND_DO = 4'h7;
  localparam logic [3:0] MODE_SIG_OR_DO = 4'h8;
  localparam logic [3:0] MODE_ANY = 4'h9;
  localparam logic [3:0] MODE_ALL = 4'hA;

  // residual source codes
  localparam logic [1:0] RES_OFF = 2'h0;
  localparam logic [1:0] RES_A = 2'h1;
  localparam logic [1:0] RES_B = 2'h2;
  localparam logic [1:0] RES_CALC = 2'h3;

  // status codes
  localparam logic [2:0] ST_NORMAL = 3'h0;
  localparam logic [2:0] ST_START = 3'h1;
  localparam logic [2:0] ST_RETRIP = 3'h2;
  localparam logic [2:0] ST_FAIL = 3'h3;
  localparam logic [2:0] ST_BLOCKED = 3'h4;

endpackage : breaker_failure_pkg

// ### logic/breaker_failure_protection.sv
// breaker-failure supervision: pick-up, criterion, block check, timers, registers
module breaker_failure_protection
  import breaker_failure_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic measTick,
  input wire logic [MAG_W-1:0] phaseMagA,
  input wire logic [MAG_W-1:0] phaseMagB,
  input wire logic [MAG_W-1:0] phaseMagC,
  input wire logic [MAG_W-1:0] residualInputA,
  input wire logic [MAG_W-1:0] residualInputB,
  input wire logic [MAG_W-1:0] computedResidual,
  input wire logic doMonitor,
  input wire logic signalMonitor,
  input wire logic blockIn,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdData,
  output logic startOut,
  output logic retripOut,
  output logic breakerFailureActive,
  output logic blockedOut,
  output logic [2:0] statusCode,
  output logic blockNotify,
  output logic blockEventPulse
);

  // pick-up with hysteresis; level given in 0.001 In
  function automatic logic pickEval(input logic was, input logic [MAG_W-1:0] mag,
                                    input logic [31:0] levelMilli);
    logic [31:0] magScaled;
    logic [31:0] relLevel;
    magScaled = 32'(mag) * 32'd100;
    relLevel = levelMilli * 32'(RELEASE_PCT);
    if (was) begin
      pickEval = !(magScaled < relLevel);
    end else begin
      pickEval = 32'(mag) > levelMilli;
    end
  endfunction : pickEval

  function automatic logic critSel(input logic [3:0] mode, input logic cur,
                                   input logic dOut, input logic sig);
    unique case (mode)
      MODE_DO: critSel = dOut;
      MODE_SIG: critSel = sig;
      MODE_CUR_AND_DO: critSel = cur & dOut;
      MODE_CUR_OR_DO: critSel = cur | dOut;
      MODE_CUR_AND_SIG: critSel = cur & sig;
      MODE_CUR_OR_SIG: critSel = cur | sig;
      MODE_SIG_AND_DO: critSel = sig & dOut;
      MODE_SIG_OR_DO: critSel = sig | dOut;
      MODE_ANY: critSel = cur | dOut | sig;
      MODE_ALL: critSel = cur & dOut & sig;
      default: critSel = cur;
    endcase
  endfunction : critSel

  function automatic logic [DELAY_W-1:0] clampDelay(input logic [31:0] v);
    clampDelay = (v > 32'(DELAY_MAX_TICKS)) ? DELAY_MAX_TICKS : v[DELAY_W-1:0];
  endfunction : clampDelay

  logic [3:0] mode_q;
  logic [1:0] resSel_q;
  logic retripEn_q;
  logic [PH_LEVEL_W-1:0] phLevel_q;
  logic [RES_LEVEL_W-1:0] resLevel_q;
  logic [DELAY_W-1:0] retripDelay_q;
  logic [DELAY_W-1:0] failDelay_q;
  logic [2:0] phPick_q;
  logic [2:0] phPick_d;
  logic resPick_q;
  logic resPick_d;
  logic cond_q;
  logic start_q;
  logic blocked_q;
  logic [DELAY_W-1:0] elapsed_q;
  logic [DELAY_W-1:0] elapsed_d;
  logic [MAG_W-1:0] startPhase_q;
  logic [MAG_W-1:0] startRes_q;
  logic [3:0] startType_q;
  logic [MAG_W-1:0] evtPhase_q;
  logic [MAG_W-1:0] evtRes_q;
  logic [3:0] evtType_q;
  logic evtFlag_q;
  logic [MAG_W-1:0] phMag [3];
  logic [MAG_W-1:0] resMag;
  logic [MAG_W-1:0] maxPhase;
  logic curPick;
  logic condNow;
  logic startNow;
  logic blockedNow;
  logic retripNow;
  logic failNow;
  logic blockRise;
  logic evtClear;

  assign phMag[0] = phaseMagA;
  assign phMag[1] = phaseMagB;
  assign phMag[2] = phaseMagC;

  always_comb begin
    unique case (resSel_q)
      RES_A: resMag = residualInputA;
      RES_B: resMag = residualInputB;
      RES_CALC: resMag = computedResidual;
      RES_OFF: resMag = '0;
    endcase
  end

  always_comb begin
    maxPhase = phMag[0];
    for (int i = 1; i < 3; i++) begin
      if (phMag[i] > maxPhase) begin
        maxPhase = phMag[i];
      end
    end
  end

  // comparators evaluated fresh each tick, so signal modes add no delay
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      phPick_d[i] = pickEval(phPick_q[i], phMag[i],
                             32'(phLevel_q) * 32'(PH_TO_MILLI));
    end
    resPick_d = (resSel_q != RES_OFF) && pickEval(resPick_q, resMag, 32'(resLevel_q));
    curPick = (|phPick_d) | resPick_d;
    condNow = critSel(mode_q, curPick, doMonitor, signalMonitor);
    startNow = condNow & !blockIn;
    blockedNow = condNow & blockIn;
  end

  // one shared counter serves both delays; cleared whenever start drops
  always_comb begin
    if (!startNow) begin
      elapsed_d = '0;
    end else if (!start_q) begin
      elapsed_d = '0;
    end else if (elapsed_q == DELAY_MAX_TICKS) begin
      elapsed_d = elapsed_q;
    end else begin
      elapsed_d = elapsed_q + DELAY_W'(1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      phPick_q <= '0;
      resPick_q <= 1'b0;
      cond_q <= 1'b0;
      start_q <= 1'b0;
      blocked_q <= 1'b0;
      elapsed_q <= '0;
    end else if (measTick) begin
      phPick_q <= phPick_d;
      resPick_q <= resPick_d;
      cond_q <= condNow;
      start_q <= startNow;
      blocked_q <= blockedNow;
      elapsed_q <= elapsed_d;
    end
  end

  assign retripNow = start_q && retripEn_q && (elapsed_q >= retripDelay_q);
  assign failNow = start_q && (elapsed_q >= failDelay_q);

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      retripOut <= 1'b0;
      breakerFailureActive <= 1'b0;
      statusCode <= ST_NORMAL;
    end else begin
      retripOut <= retripNow;
      breakerFailureActive <= failNow;
      if (blocked_q) begin
        statusCode <= ST_BLOCKED;
      end else if (failNow) begin
        statusCode <= ST_FAIL;
      end else if (retripNow) begin
        statusCode <= ST_RETRIP;
      end else if (start_q) begin
        statusCode <= ST_START;
      end else begin
        statusCode <= ST_NORMAL;
      end
    end
  end

  assign startOut = start_q;
  assign blockedOut = blocked_q;

  // start-time values kept so a later block can report them
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      startPhase_q <= '0;
      startRes_q <= '0;
      startType_q <= '0;
    end else if (measTick && condNow && !cond_q) begin
      startPhase_q <= maxPhase;
      startRes_q <= resMag;
      startType_q <= {resPick_d, phPick_d};
    end
  end

  assign blockRise = measTick && blockedNow && !blocked_q;
  assign evtClear = regWr && (regAddr == OFS_BLOCK_EVT) && regWrData[EVT_FLAG_BIT];

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      evtPhase_q <= '0;
      evtRes_q <= '0;
      evtType_q <= '0;
      evtFlag_q <= 1'b0;
      blockEventPulse <= 1'b0;
    end else begin
      blockEventPulse <= blockRise;
      if (blockRise) begin
        // a block on the very pick-up tick reports the live values
        evtPhase_q <= cond_q ? startPhase_q : maxPhase;
        evtRes_q <= cond_q ? startRes_q : resMag;
        evtType_q <= cond_q ? startType_q : {resPick_d, phPick_d};
        evtFlag_q <= 1'b1;
      end else if (evtClear) begin
        evtFlag_q <= 1'b0;
      end
    end
  end

  assign blockNotify = evtFlag_q;

  // settings registers; out-of-range levels and delays are clamped
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      mode_q <= MODE_RST;
      resSel_q <= RESSEL_RST;
      retripEn_q <= RETRIP_EN_RST;
      phLevel_q <= PH_LEVEL_RST;
      resLevel_q <= RES_LEVEL_RST;
      retripDelay_q <= RETRIP_DELAY_RST;
      failDelay_q <= FAIL_DELAY_RST;
    end else if (regWr) begin
      unique case (regAddr)
        OFS_CTRL: begin
          mode_q <= regWrData[CTRL_MODE_LSB +: 4];
          resSel_q <= regWrData[CTRL_RESSEL_LSB +: 2];
          retripEn_q <= regWrData[CTRL_RETRIP_EN_BIT];
        end
        OFS_PH_LEVEL: begin
          if (regWrData < 32'(PH_LEVEL_MIN)) begin
            phLevel_q <= PH_LEVEL_MIN;
          end else if (regWrData > 32'(PH_LEVEL_MAX)) begin
            phLevel_q <= PH_LEVEL_MAX;
          end else begin
            phLevel_q <= regWrData[PH_LEVEL_W-1:0];
          end
        end
        OFS_RES_LEVEL: begin
          if (regWrData < 32'(RES_LEVEL_MIN)) begin
            resLevel_q <= RES_LEVEL_MIN;
          end else if (regWrData > 32'(RES_LEVEL_MAX)) begin
            resLevel_q <= RES_LEVEL_MAX;
          end else begin
            resLevel_q <= regWrData[RES_LEVEL_W-1:0];
          end
        end
        OFS_RETRIP_DELAY: retripDelay_q <= clampDelay(regWrData);
        OFS_FAIL_DELAY: failDelay_q <= clampDelay(regWrData);
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      regRdData <= '0;
    end else if (regRd) begin
      unique case (regAddr)
        OFS_CTRL: regRdData <= {23'h00_0000, retripEn_q, 2'h0, resSel_q, mode_q};
        OFS_PH_LEVEL: regRdData <= {20'h0_0000, phLevel_q};
        OFS_RES_LEVEL: regRdData <= {16'h0000, resLevel_q};
        // retrip delay reads as zero while retrip is disabled
        OFS_RETRIP_DELAY: regRdData <= retripEn_q ? {13'h0000, retripDelay_q} : '0;
        OFS_FAIL_DELAY: regRdData <= {13'h0000, failDelay_q};
        OFS_STATUS: regRdData <= {20'h0_0000, resPick_q, phPick_q, blocked_q,
                                  breakerFailureActive, retripOut, start_q,
                                  1'b0, statusCode};
        OFS_BLOCK_EVT: regRdData <= {evtFlag_q, 27'h000_0000, evtType_q};
        OFS_EVT_PHASE: regRdData <= {16'h0000, evtPhase_q};
        OFS_EVT_RES: regRdData <= {16'h0000, evtRes_q};
        OFS_ELAPSED: regRdData <= {13'h0000, elapsed_q};
        default: regRdData <= '0;
      endcase
    end else begin
      regRdData <= '0;
    end
  end

  sequence s_blockedPick;
    measTick && condNow && blockIn;
  endsequence

  sequence s_freshStart;
    measTick && startNow && !start_q;
  endsequence

  property p_startNeedsClear;
    @(posedge sys_clk) disable iff (sys_rst) measTick && blockIn |=> !startOut;
  endproperty
  a_startNeedsClear: assert property (p_startNeedsClear) else $error("start while blocked");

  property p_blockedNoRun;
    @(posedge sys_clk) disable iff (sys_rst)
      s_blockedPick |=> blockedOut && !startOut ##1 !retripOut && !breakerFailureActive;
  endproperty
  a_blockedNoRun: assert property (p_blockedNoRun) else $error("timers ran when blocked");

  property p_blockSampled;
    @(posedge sys_clk) disable iff (sys_rst)
      measTick && startOut && blockIn |=> !startOut && elapsed_q == '0;
  endproperty
  a_blockSampled: assert property (p_blockSampled) else $error("block did not drop start");

  property p_statusBlocked;
    @(posedge sys_clk) disable iff (sys_rst) $rose(blockedOut) |=> statusCode == ST_BLOCKED;
  endproperty
  a_statusBlocked: assert property (p_statusBlocked) else $error("status not blocked");

  property p_retripGated;
    @(posedge sys_clk) disable iff (sys_rst) !retripEn_q |=> !retripOut;
  endproperty
  a_retripGated: assert property (p_retripGated) else $error("retrip while disabled");

  property p_failDelay;
    @(posedge sys_clk) disable iff (sys_rst)
      startOut && elapsed_q >= failDelay_q |=> breakerFailureActive && statusCode == ST_FAIL;
  endproperty
  a_failDelay: assert property (p_failDelay) else $error("failure output late");

  property p_signalNoDelay;
    @(posedge sys_clk) disable iff (sys_rst)
      measTick && mode_q == MODE_SIG && signalMonitor && !blockIn |=> startOut;
  endproperty
  a_signalNoDelay: assert property (p_signalNoDelay) else $error("signal start delayed");

  property p_bothTimersTogether;
    @(posedge sys_clk) disable iff (sys_rst)
      s_freshStart |=> elapsed_q == '0 ##1 retripOut == (retripEn_q && retripDelay_q == '0);
  endproperty
  a_bothTimersTogether: assert property (p_bothTimersTogether) else $error("timer start");

  property p_andModeHold;
    @(posedge sys_clk) disable iff (sys_rst)
      measTick && mode_q == MODE_CUR_AND_DO && !doMonitor |=> !startOut && elapsed_q == '0;
  endproperty
  a_andModeHold: assert property (p_andModeHold) else $error("and mode ran");

  property p_releaseClears;
    @(posedge sys_clk) disable iff (sys_rst) measTick && !condNow |=> elapsed_q == '0;
  endproperty
  a_releaseClears: assert property (p_releaseClears) else $error("counter not cleared");

  // or mode: the trip output alone must keep the timers running
  property p_orModeRuns;
    @(posedge sys_clk) disable iff (sys_rst)
      measTick && mode_q == MODE_CUR_OR_DO && doMonitor && !blockIn |=> startOut;
  endproperty
  a_orModeRuns: assert property (p_orModeRuns) else $error("or mode held");

  property p_residualOff;
    @(posedge sys_clk) disable iff (sys_rst) measTick && resSel_q == RES_OFF |=> !resPick_q;
  endproperty
  a_residualOff: assert property (p_residualOff) else $error("residual picked while off");

endmodule : breaker_failure_protection

// ### tb/breaker_model.sv
// feeder breaker and incomer breaker seen from the supervision block
module breaker_model (
  input wire logic sys_clk,
  input wire logic rearm,
  input wire logic stuck,
  input wire logic primaryTrip,
  input wire logic secondCoil,
  input wire logic incomerTrip,
  input wire logic [15:0] faultMag,
  output logic [15:0] lineMag
);
  timeunit 1ns;
  timeprecision 1ps;
  logic closed_q = 1'b1;
  // a stuck breaker ignores both of its own coils; only the incomer clears it
  always_ff @(posedge sys_clk) begin
    if (rearm) begin
      closed_q <= 1'b1;
    end else if (incomerTrip || (!stuck && (primaryTrip || secondCoil))) begin
      closed_q <= 1'b0;
    end
  end
  // an open breaker carries no current
  assign lineMag = closed_q ? faultMag : 16'h0000;
endmodule : breaker_model

// ### tb/breaker_failure_protection_bench.sv
// self-checking bench for the breaker-failure supervision block
module breaker_failure_protection_bench
  import breaker_failure_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, sys_rst, measTick, doMonitor, signalMonitor, blockIn, regWr, regRd;
  logic [15:0] phaseMagA, phaseMagB, phaseMagC, residualInputA, residualInputB;
  logic [15:0] computedResidual, faultMag;
  logic [7:0] regAddr;
  logic [31:0] regWrData, regRdData, rdVal;
  logic startOut, retripOut, breakerFailureActive, blockedOut, blockNotify, blockEventPulse;
  logic [2:0] statusCode;
  logic rearm, stuck;
  int errCount, nCompared, pulseCnt;

  breaker_failure_protection i_breaker_failure_protection (.sys_clk(sys_clk),
    .sys_rst(sys_rst), .measTick(measTick), .phaseMagA(phaseMagA), .phaseMagB(phaseMagB),
    .phaseMagC(phaseMagC), .residualInputA(residualInputA), .residualInputB(residualInputB),
    .computedResidual(computedResidual), .doMonitor(doMonitor),
    .signalMonitor(signalMonitor), .blockIn(blockIn), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .startOut(startOut), .retripOut(retripOut), .breakerFailureActive(breakerFailureActive),
    .blockedOut(blockedOut), .statusCode(statusCode), .blockNotify(blockNotify),
    .blockEventPulse(blockEventPulse));

  breaker_model i_breaker_model (.sys_clk(sys_clk), .rearm(rearm), .stuck(stuck),
    .primaryTrip(doMonitor), .secondCoil(retripOut), .incomerTrip(breakerFailureActive),
    .faultMag(faultMag), .lineMag(phaseMagA));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp) begin
      errCount++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic complete_run();
    $display("compared %0d mismatches %0d", nCompared, errCount);
    if (errCount == 0 && nCompared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask : wr

  task automatic rdChk(input string what, input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1;
    rdVal = regRdData;
    check(what, rdVal, exp);
    @(posedge sys_clk);
  endtask : rdChk

  // one evaluation tick, then time for outputs to land; block pulses counted
  task automatic tick();
    @(posedge sys_clk);
    measTick <= 1'b1;
    @(posedge sys_clk);
    measTick <= 1'b0;
    pulseCnt = 0;
    repeat (4) begin
      #1;
      if (blockEventPulse === 1'b1) pulseCnt++;
      @(posedge sys_clk);
    end
  endtask : tick

  task automatic drive(input logic [15:0] cur, input logic dOn, input logic sOn);
    @(posedge sys_clk);
    faultMag <= cur;
    doMonitor <= dOn;
    signalMonitor <= sOn;
  endtask : drive

  task automatic closeBreaker();
    @(posedge sys_clk);
    rearm <= 1'b1;
    @(posedge sys_clk);
    rearm <= 1'b0;
  endtask : closeBreaker

  task automatic outs(input logic [3:0] e, input logic [2:0] st);
    check("outputs", 32'({startOut, retripOut, breakerFailureActive, blockedOut}), 32'(e));
    check("status", 32'(statusCode), 32'(st));
  endtask : outs

  task automatic test_reset();
    rdChk("ctrl", OFS_CTRL, 32'h0000_0100);
    #1;
    check("idle read data", regRdData, 32'h0000_0000);
    rdChk("phase level", OFS_PH_LEVEL, 32'h0000_0014);
    rdChk("res level", OFS_RES_LEVEL, 32'h0000_04B0);
    rdChk("retrip delay", OFS_RETRIP_DELAY, 32'h0000_0014);
    rdChk("fail delay", OFS_FAIL_DELAY, 32'h0000_0028);
    rdChk("unmapped", 8'h40, 32'h0000_0000);
    wr(OFS_PH_LEVEL, 32'h0000_FFFF);
    rdChk("phase level max", OFS_PH_LEVEL, 32'h0000_0FA0);
    wr(OFS_RES_LEVEL, 32'h0000_0000);
    rdChk("res level min", OFS_RES_LEVEL, 32'h0000_0005);
    wr(OFS_PH_LEVEL, 32'h0000_0014);
    wr(OFS_RES_LEVEL, 32'h0000_04B0);
    outs(4'b0000, 3'h0);
    $display("test reset done");
  endtask : test_reset

  task automatic test_current();
    // failure delay kept above the retrip delay
    wr(OFS_RETRIP_DELAY, 32'h0000_0002);
    wr(OFS_FAIL_DELAY, 32'h0000_0003);
    phaseMagC <= 16'h00C8;
    tick();
    outs(4'b0000, 3'h0);
    phaseMagC <= 16'h00C9;
    tick();
    outs(4'b1000, 3'h1);
    tick();
    outs(4'b1000, 3'h1);
    tick();
    outs(4'b1100, 3'h2);
    tick();
    outs(4'b1110, 3'h3);
    tick();
    outs(4'b1110, 3'h3);
    phaseMagC <= 16'h00C2;
    tick();
    outs(4'b1110, 3'h3);
    phaseMagC <= 16'h00C1;
    tick();
    outs(4'b0000, 3'h0);
    phaseMagC <= 16'h00C9;
    tick();
    tick();
    rdChk("elapsed", OFS_ELAPSED, 32'h0000_0001);
    phaseMagC <= 16'h0000;
    tick();
    $display("test current done");
  endtask : test_current

  task automatic test_residual();
    for (int s = 0; s < 4; s++) begin
      wr(OFS_CTRL, 32'h0000_0100 | 32'(s << 4));
      residualInputA <= (s < 2) ? 16'h04B1 : 16'h0000;
      residualInputB <= (s == 0 || s == 2) ? 16'h04B1 : 16'h0000;
      computedResidual <= (s == 0 || s == 3) ? 16'h04B1 : 16'h0000;
      tick();
      check("residual start", 32'(startOut), 32'(s != 0));
      residualInputA <= 16'h0000;
      residualInputB <= 16'h0000;
      computedResidual <= 16'h0000;
      tick();
      check("residual release", 32'(startOut), 32'h0000_0000);
    end
    $display("test residual done");
  endtask : test_residual

  function automatic logic crit(input int m, input logic c, input logic d, input logic g);
    case (m)
      1: return d;
      2: return g;
      3: return c & d;
      4: return c | d;
      5: return c & g;
      6: return c | g;
      7: return g & d;
      8: return g | d;
      9: return c | d | g;
      10: return c & d & g;
      default: return c;
    endcase
  endfunction : crit

  task automatic test_modes();
    logic [2:0] k;
    // the incomer opened the breaker in the current test
    closeBreaker();
    wr(OFS_FAIL_DELAY, 32'h0000_0064);
    // codes above ten must behave as current only
    for (int m = 0; m < 12; m++) begin
      wr(OFS_CTRL, 32'h0000_0100 | 32'(m));
      for (int i = 0; i < 8; i++) begin
        k = 3'(i);
        drive(k[0] ? 16'h012C : 16'h0000, k[1], k[2]);
        tick();
        check("mode start", 32'(startOut), 32'(crit(m, k[0], k[1], k[2])));
      end
    end
    drive(16'h0000, 1'b0, 1'b0);
    wr(OFS_CTRL, 32'h0000_0100);
    tick();
    $display("test modes done");
  endtask : test_modes

  task automatic test_block();
    wr(OFS_FAIL_DELAY, 32'h0000_0003);
    // blocking raised long before any delay could expire
    blockIn <= 1'b1;
    drive(16'h012C, 1'b0, 1'b0);
    tick();
    outs(4'b0001, 3'h4);
    check("block pulse", 32'(pulseCnt), 32'h0000_0001);
    check("notify", 32'(blockNotify), 32'h0000_0001);
    rdChk("block event", OFS_BLOCK_EVT, 32'h8000_0001);
    rdChk("event phase", OFS_EVT_PHASE, 32'h0000_012C);
    tick();
    tick();
    tick();
    outs(4'b0001, 3'h4);
    rdChk("elapsed blocked", OFS_ELAPSED, 32'h0000_0000);
    wr(OFS_BLOCK_EVT, 32'h8000_0000);
    rdChk("event cleared", OFS_BLOCK_EVT, 32'h0000_0001);
    blockIn <= 1'b0;
    tick();
    outs(4'b1000, 3'h1);
    tick();
    blockIn <= 1'b1;
    tick();
    outs(4'b0001, 3'h4);
    check("second pulse", 32'(pulseCnt), 32'h0000_0001);
    rdChk("elapsed released", OFS_ELAPSED, 32'h0000_0000);
    blockIn <= 1'b0;
    drive(16'h0000, 1'b0, 1'b0);
    tick();
    $display("test block done");
  endtask : test_block

  task automatic test_retrip_off();
    wr(OFS_CTRL, 32'h0000_0000);
    rdChk("retrip delay hidden", OFS_RETRIP_DELAY, 32'h0000_0000);
    drive(16'h012C, 1'b0, 1'b0);
    repeat (4) tick();
    outs(4'b1010, 3'h3);
    // incomer has opened the stuck feeder, so the current is gone
    tick();
    outs(4'b0000, 3'h0);
    closeBreaker();
    $display("test retrip off done");
  endtask : test_retrip_off

  initial begin
    repeat (60000) @(posedge sys_clk);
    errCount++;
    $display("[ERR] run length expected finish seen hang");
    complete_run();
  end

  initial begin
    sys_rst = 1'b1;
    measTick = 1'b0;
    doMonitor = 1'b0;
    signalMonitor = 1'b0;
    blockIn = 1'b0;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 8'h00;
    regWrData = 32'h0000_0000;
    phaseMagB = 16'h0000;
    phaseMagC = 16'h0000;
    residualInputA = 16'h0000;
    residualInputB = 16'h0000;
    computedResidual = 16'h0000;
    faultMag = 16'h0000;
    rearm = 1'b0;
    stuck = 1'b1;
    errCount = 0;
    nCompared = 0;
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'b0;
    test_reset();
    test_current();
    test_residual();
    test_modes();
    test_block();
    test_retrip_off();
    complete_run();
  end
endmodule : breaker_failure_protection_bench
